// ---- rtl/aeu_address_unit.sv ----
`timescale 1ns/10ps
module aeu_address_unit
    import aeu_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    input wire logic req_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] byte1_i,
    input wire logic [7:0] byte2_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] index_i,
    input wire logic branch_cond_i,
    input wire logic [7:0] mem_data_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    input wire logic alu_cin_i,
    output logic ready_o,
    output logic done_o,
    output aeu_mode_e mode_o,
    output aeu_class_e class_o,
    output logic addr_valid_o,
    output logic [15:0] effective_address_o,
    output logic [7:0] addr_hi_o,
    output logic [7:0] addr_lo_o,
    output logic [15:0] next_pc_o,
    output logic branch_taken_o,
    output logic [7:0] bit_write_data_o,
    output logic carry_o,
    output logic carry_update_o,
    output logic half_carry_o
);

    // =========================================================
    // request capture
    aeu_state_e state_q;
    aeu_state_e state_d;
    logic [7:0] op_q;
    logic [7:0] b1_q;
    logic [7:0] b2_q;
    logic [15:0] pc_q;
    logic [7:0] x_q;
    logic cond_q;
    logic [7:0] mem_q;
    logic [7:0] alu_a_q;
    logic [7:0] alu_b_q;
    logic alu_cin_q;
    logic take;
    aeu_mode_e mode_w;
    aeu_class_e class_w;

    assign ready_o = (state_q == AEU_IDLE);
    assign done_o = (state_q == AEU_DONE);
    assign take = ready_o && req_i;

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            op_q <= AEU_BYTE_RESET;
            b1_q <= AEU_BYTE_RESET;
            b2_q <= AEU_BYTE_RESET;
            pc_q <= AEU_WORD_RESET;
            x_q <= AEU_BYTE_RESET;
            cond_q <= 1'b0;
            mem_q <= AEU_BYTE_RESET;
            alu_a_q <= AEU_BYTE_RESET;
            alu_b_q <= AEU_BYTE_RESET;
            alu_cin_q <= 1'b0;
        end
        else if (ce_i && take)
        begin
            op_q <= opcode_i;
            b1_q <= byte1_i;
            b2_q <= byte2_i;
            pc_q <= pc_i;
            x_q <= index_i;
            cond_q <= branch_cond_i;
            mem_q <= mem_data_i;
            alu_a_q <= alu_a_i;
            alu_b_q <= alu_b_i;
            alu_cin_q <= alu_cin_i;
        end
    end

    aeu_mode_decode u_decode (
        .opcode_i(op_q),
        .mode_o(mode_w),
        .class_o(class_w)
    );

    // =========================================================
    // sequencer: one request at a time, done one cycle
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            AEU_IDLE:
            begin
                if (req_i)
                begin
                    state_d = AEU_CALC;
                end
            end
            AEU_CALC:
            begin
                state_d = AEU_DONE;
            end
            AEU_DONE:
            begin
                state_d = AEU_IDLE;
            end
            default:
            begin
                state_d = AEU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= AEU_IDLE;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // address and pc arithmetic
    logic [8:0] idx_sum;
    logic [7:0] hi_d;
    logic [7:0] lo_d;
    logic valid_d;
    logic [15:0] pc_d;
    logic taken_d;
    logic test_bit;
    logic [7:0] wdata_d;
    logic carry_upd_d;
    logic [4:0] nibble_sum;

    // low byte of word offset uses the second byte, byte offset the first
    assign idx_sum = aeu_add8(x_q, (mode_w == AEU_INDEXED_WORD_OFFSET_MODE) ? b2_q : b1_q);
    assign test_bit = mem_q[op_q[3:1]];
    assign nibble_sum = {1'b0, alu_a_q[3:0]} + {1'b0, alu_b_q[3:0]} + {4'h0, alu_cin_q};

    always_comb
    begin
        hi_d = AEU_PAGE_ZERO;
        lo_d = AEU_BYTE_RESET;
        valid_d = 1'b1;
        pc_d = pc_q + AEU_PC_STEP_1;
        taken_d = 1'b0;
        wdata_d = mem_q;
        carry_upd_d = 1'b0;
        unique case (mode_w)
            AEU_EXTENDED_MODE:
            begin
                hi_d = b1_q;
                lo_d = b2_q;
                pc_d = pc_q + AEU_PC_STEP_3;
            end
            AEU_INDEXED_MODE:
            begin
                lo_d = x_q;
                pc_d = pc_q + AEU_PC_STEP_1;
            end
            AEU_INDEXED_BYTE_OFFSET_MODE:
            begin
                hi_d = {7'h00, idx_sum[8]};
                lo_d = idx_sum[7:0];
                pc_d = pc_q + AEU_PC_STEP_2;
            end
            AEU_INDEXED_WORD_OFFSET_MODE:
            begin
                hi_d = b1_q + {7'h00, idx_sum[8]};
                lo_d = idx_sum[7:0];
                pc_d = pc_q + AEU_PC_STEP_3;
            end
            AEU_DIRECT_MODE:
            begin
                lo_d = b1_q;
                pc_d = pc_q + AEU_PC_STEP_2;
            end
            AEU_RELATIVE_MODE:
            begin
                valid_d = 1'b0;
                taken_d = cond_q;
                pc_d = cond_q ? (pc_q + AEU_PC_STEP_2 + aeu_sext16(b1_q))
                              : (pc_q + AEU_PC_STEP_2);
            end
            AEU_BIT_SET_CLEAR_MODE:
            begin
                // one bit changed, set when opcode bit 0 low
                lo_d = b1_q;
                pc_d = pc_q + AEU_PC_STEP_2;
                wdata_d[op_q[3:1]] = ~op_q[0];
            end
            AEU_BIT_TEST_BRANCH_MODE:
            begin
                lo_d = b1_q;
                taken_d = (test_bit == ~op_q[0]);
                // fall through at pc plus three
                pc_d = taken_d ? (pc_q + AEU_PC_STEP_3 + aeu_sext16(b2_q))
                               : (pc_q + AEU_PC_STEP_3);
                carry_upd_d = 1'b1;
            end
            AEU_IMMEDIATE_MODE:
            begin
                valid_d = 1'b0;
                pc_d = pc_q + AEU_PC_STEP_2;
            end
            AEU_INHERENT_MODE:
            begin
                valid_d = 1'b0;
            end
            default:
            begin
                valid_d = 1'b0;
            end
        endcase
    end

    // =========================================================
    // result registers, loaded in calc, held until next request
    always_ff @(posedge clock_i)
    begin
        if (!reset_n_i)
        begin
            mode_o <= AEU_INHERENT_MODE;
            class_o <= AEU_CLASS_CONTROL;
            addr_valid_o <= 1'b0;
            addr_hi_o <= AEU_BYTE_RESET;
            addr_lo_o <= AEU_BYTE_RESET;
            next_pc_o <= AEU_WORD_RESET;
            branch_taken_o <= 1'b0;
            bit_write_data_o <= AEU_BYTE_RESET;
            carry_o <= 1'b0;
            carry_update_o <= 1'b0;
            half_carry_o <= 1'b0;
        end
        else if (ce_i && state_q == AEU_CALC)
        begin
            mode_o <= mode_w;
            class_o <= class_w;
            addr_valid_o <= valid_d;
            addr_hi_o <= hi_d;
            addr_lo_o <= lo_d;
            next_pc_o <= pc_d;
            branch_taken_o <= taken_d;
            bit_write_data_o <= wdata_d;
            carry_o <= carry_upd_d ? test_bit : 1'b0;
            carry_update_o <= carry_upd_d;
            half_carry_o <= (nibble_sum > AEU_NIBBLE_MAX);
        end
    end

    assign effective_address_o = {addr_hi_o, addr_lo_o};

    // =========================================================
    // assertions
    sequence seq_calc_step;
        state_q == AEU_CALC && ce_i;
    endsequence

    sequence seq_result;
        done_o && addr_valid_o == valid_d;
    endsequence

    property p_done_after_calc;
        @(posedge clock_i) disable iff (!reset_n_i)
        seq_calc_step |=> seq_result;
    endproperty

    a_done_after_calc: assert property (p_done_after_calc)
        else $error("result not presented after calc");

    a_class_from_nibble: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && op_q[7:4] == AEU_NIB_BIT_TEST |-> class_o == AEU_CLASS_BIT_TEST
            && mode_o == AEU_BIT_TEST_BRANCH_MODE)
        else $error("bit test nibble misclassified");

    a_extended_address: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_EXTENDED_MODE |-> effective_address_o == {b1_q, b2_q}
            && next_pc_o == pc_q + AEU_PC_STEP_3)
        else $error("extended address or pc wrong");

    a_indexed_address: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_INDEXED_MODE |-> addr_hi_o == AEU_PAGE_ZERO
            && addr_lo_o == x_q && next_pc_o == pc_q + AEU_PC_STEP_1)
        else $error("indexed address wrong");

    a_byte_offset_sum: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_INDEXED_BYTE_OFFSET_MODE |->
            effective_address_o == {8'h00, x_q} + {8'h00, b1_q}
            && next_pc_o == pc_q + AEU_PC_STEP_2)
        else $error("byte offset address wrong");

    a_word_offset_sum: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_INDEXED_WORD_OFFSET_MODE |->
            effective_address_o == {b1_q, b2_q} + {8'h00, x_q}
            && next_pc_o == pc_q + AEU_PC_STEP_3)
        else $error("word offset address wrong");

    a_relative_target: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_RELATIVE_MODE |-> next_pc_o == (cond_q
            ? pc_q + AEU_PC_STEP_2 + {{8{b1_q[7]}}, b1_q} : pc_q + AEU_PC_STEP_2)
            && branch_taken_o == cond_q)
        else $error("relative target wrong");

    a_bit_modify_data: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_BIT_SET_CLEAR_MODE |->
            bit_write_data_o[op_q[3:1]] == !op_q[0]
            && (bit_write_data_o ^ mem_q) == (mem_q[op_q[3:1]] == !op_q[0] ? 8'h00
                : (8'h01 << op_q[3:1]))
            && effective_address_o == {8'h00, b1_q} && next_pc_o == pc_q + AEU_PC_STEP_2)
        else $error("bit modify result wrong");

    a_bit_test_taken: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_BIT_TEST_BRANCH_MODE
            && mem_q[op_q[3:1]] != op_q[0] |-> branch_taken_o
            && next_pc_o == pc_q + AEU_PC_STEP_3 + {{8{b2_q[7]}}, b2_q})
        else $error("bit test branch target wrong");

    a_bit_test_fall: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_BIT_TEST_BRANCH_MODE
            && mem_q[op_q[3:1]] == op_q[0] |-> !branch_taken_o
            && next_pc_o == pc_q + AEU_PC_STEP_3)
        else $error("bit test fall through wrong");

    a_bit_test_carry: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        seq_calc_step ##0 mode_w == AEU_BIT_TEST_BRANCH_MODE |=>
            carry_update_o && carry_o == mem_q[op_q[3:1]])
        else $error("tested bit not in carry");

    a_half_carry_bit3: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o |-> half_carry_o == ((alu_a_q[3:0] + alu_b_q[3:0] + alu_cin_q) > 15))
        else $error("half carry wrong");

    a_direct_address: assert property (
        @(posedge clock_i) disable iff (!reset_n_i)
        done_o && mode_o == AEU_DIRECT_MODE |-> addr_hi_o == AEU_PAGE_ZERO
            && addr_lo_o == b1_q && next_pc_o == pc_q + AEU_PC_STEP_2)
        else $error("direct address wrong");

endmodule // aeu_address_unit

// ---- rtl/aeu_pkg.sv ----
package aeu_pkg;

    // =========================================================
    // addressing modes and opcode classes
    typedef enum logic [3:0] {
        AEU_INHERENT_MODE = 4'h0,
        AEU_IMMEDIATE_MODE = 4'h1,
        AEU_DIRECT_MODE = 4'h2,
        AEU_EXTENDED_MODE = 4'h3,
        AEU_RELATIVE_MODE = 4'h4,
        AEU_INDEXED_MODE = 4'h5,
        AEU_INDEXED_BYTE_OFFSET_MODE = 4'h6,
        AEU_INDEXED_WORD_OFFSET_MODE = 4'h7,
        AEU_BIT_SET_CLEAR_MODE = 4'h8,
        AEU_BIT_TEST_BRANCH_MODE = 4'h9
    } aeu_mode_e;

    typedef enum logic [2:0] {
        AEU_CLASS_BIT_TEST = 3'h0,
        AEU_CLASS_BIT_MODIFY = 3'h1,
        AEU_CLASS_BRANCH = 3'h2,
        AEU_CLASS_READ_MODIFY_WRITE = 3'h3,
        AEU_CLASS_CONTROL = 3'h4,
        AEU_CLASS_REGISTER_MEMORY = 3'h5
    } aeu_class_e;

    // =========================================================
    // sequencer states, gray along idle, calc, done
    typedef enum logic [1:0] {
        AEU_IDLE = 2'b00,
        AEU_CALC = 2'b01,
        AEU_DONE = 2'b11
    } aeu_state_e;

    // =========================================================
    // upper opcode nibble codes
    localparam logic [3:0] AEU_NIB_BIT_TEST = 4'h0;
    localparam logic [3:0] AEU_NIB_BIT_MODIFY = 4'h1;
    localparam logic [3:0] AEU_NIB_BRANCH = 4'h2;
    localparam logic [3:0] AEU_NIB_RMW_DIRECT = 4'h3;
    localparam logic [3:0] AEU_NIB_RMW_ACC = 4'h4;
    localparam logic [3:0] AEU_NIB_RMW_INDEX_REG = 4'h5;
    localparam logic [3:0] AEU_NIB_RMW_BYTE_OFFSET = 4'h6;
    localparam logic [3:0] AEU_NIB_RMW_INDEXED = 4'h7;
    localparam logic [3:0] AEU_NIB_CONTROL_A = 4'h8;
    localparam logic [3:0] AEU_NIB_CONTROL_B = 4'h9;
    localparam logic [3:0] AEU_NIB_IMMEDIATE = 4'ha;
    localparam logic [3:0] AEU_NIB_DIRECT = 4'hb;
    localparam logic [3:0] AEU_NIB_EXTENDED = 4'hc;
    localparam logic [3:0] AEU_NIB_WORD_OFFSET = 4'hd;
    localparam logic [3:0] AEU_NIB_BYTE_OFFSET = 4'he;
    localparam logic [3:0] AEU_NIB_INDEXED = 4'hf;

    // =========================================================
    // program counter advances and reset values
    localparam logic [15:0] AEU_PC_STEP_1 = 16'h0001;
    localparam logic [15:0] AEU_PC_STEP_2 = 16'h0002;
    localparam logic [15:0] AEU_PC_STEP_3 = 16'h0003;
    localparam logic [7:0] AEU_PAGE_ZERO = 8'h00;
    localparam logic [7:0] AEU_BYTE_RESET = 8'h00;
    localparam logic [15:0] AEU_WORD_RESET = 16'h0000;
    localparam logic [4:0] AEU_NIBBLE_MAX = 5'h0f;

    // =========================================================
    // shared arithmetic
    function automatic logic [8:0] aeu_add8(input logic [7:0] a, input logic [7:0] b);
        aeu_add8 = {1'b0, a} + {1'b0, b};
    endfunction

    function automatic logic [15:0] aeu_sext16(input logic [7:0] b);
        aeu_sext16 = {{8{b[7]}}, b};
    endfunction

endpackage

// ---- rtl/aeu_mode_decode.sv ----
`timescale 1ns/10ps
module aeu_mode_decode
    import aeu_pkg::*;
(
    input wire logic [7:0] opcode_i,
    output aeu_mode_e mode_o,
    output aeu_class_e class_o
);

    // =========================================================
    // classify by upper nibble
    always_comb
    begin
        mode_o = AEU_INHERENT_MODE;
        class_o = AEU_CLASS_CONTROL;
        unique case (opcode_i[7:4])
            AEU_NIB_BIT_TEST:
            begin
                mode_o = AEU_BIT_TEST_BRANCH_MODE;
                class_o = AEU_CLASS_BIT_TEST;
            end
            AEU_NIB_BIT_MODIFY:
            begin
                mode_o = AEU_BIT_SET_CLEAR_MODE;
                class_o = AEU_CLASS_BIT_MODIFY;
            end
            AEU_NIB_BRANCH:
            begin
                mode_o = AEU_RELATIVE_MODE;
                class_o = AEU_CLASS_BRANCH;
            end
            AEU_NIB_RMW_DIRECT:
            begin
                mode_o = AEU_DIRECT_MODE;
                class_o = AEU_CLASS_READ_MODIFY_WRITE;
            end
            AEU_NIB_RMW_ACC, AEU_NIB_RMW_INDEX_REG:
            begin
                mode_o = AEU_INHERENT_MODE;
                class_o = AEU_CLASS_READ_MODIFY_WRITE;
            end
            AEU_NIB_RMW_BYTE_OFFSET:
            begin
                mode_o = AEU_INDEXED_BYTE_OFFSET_MODE;
                class_o = AEU_CLASS_READ_MODIFY_WRITE;
            end
            AEU_NIB_RMW_INDEXED:
            begin
                mode_o = AEU_INDEXED_MODE;
                class_o = AEU_CLASS_READ_MODIFY_WRITE;
            end
            AEU_NIB_CONTROL_A, AEU_NIB_CONTROL_B:
            begin
                mode_o = AEU_INHERENT_MODE;
                class_o = AEU_CLASS_CONTROL;
            end
            AEU_NIB_IMMEDIATE:
            begin
                mode_o = AEU_IMMEDIATE_MODE;
                class_o = AEU_CLASS_REGISTER_MEMORY;
            end
            AEU_NIB_DIRECT:
            begin
                mode_o = AEU_DIRECT_MODE;
                class_o = AEU_CLASS_REGISTER_MEMORY;
            end
            AEU_NIB_EXTENDED:
            begin
                mode_o = AEU_EXTENDED_MODE;
                class_o = AEU_CLASS_REGISTER_MEMORY;
            end
            AEU_NIB_WORD_OFFSET:
            begin
                mode_o = AEU_INDEXED_WORD_OFFSET_MODE;
                class_o = AEU_CLASS_REGISTER_MEMORY;
            end
            AEU_NIB_BYTE_OFFSET:
            begin
                mode_o = AEU_INDEXED_BYTE_OFFSET_MODE;
                class_o = AEU_CLASS_REGISTER_MEMORY;
            end
            AEU_NIB_INDEXED:
            begin
                mode_o = AEU_INDEXED_MODE;
                class_o = AEU_CLASS_REGISTER_MEMORY;
            end
        endcase
    end

endmodule // aeu_mode_decode

// ---- verification/aeu_mem_model.sv ----
`timescale 1ns/10ps
// =========================================================
// program and page-zero memory beside the address unit
module aeu_mem_model (
    input wire logic [15:0] pc_i,
    output logic [7:0] opcode_o,
    output logic [7:0] byte1_o,
    output logic [7:0] byte2_o,
    output logic [7:0] data_o
);
    logic [7:0] mem_q [0:65535];

    // unwritten bytes read as x, so stale data never passes as a match
    assign opcode_o = mem_q[pc_i];
    assign byte1_o = mem_q[pc_i + 16'h0001];
    assign byte2_o = mem_q[pc_i + 16'h0002];
    // operand byte of page zero, high address byte zero
    assign data_o = mem_q[{8'h00, byte1_o}];

    task automatic put(input logic [15:0] a, input logic [7:0] d);
        mem_q[a] = d;
    endtask
endmodule // aeu_mem_model

// ---- verification/test_addressing_mode_ea_unit.sv ----
`timescale 1ns/10ps
module test_addressing_mode_ea_unit;
    import aeu_pkg::*;
    typedef struct packed {
        logic [7:0] op, b1, b2;
        logic [15:0] pc;
        logic [7:0] x;
        logic cond;
        logic [7:0] md;
        logic [15:0] ea, npc;
        logic tk, cy;
        logic [7:0] wd;
        logic hc;
    } aeu_row_s;

    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic req_i = 1'b0;
    logic [15:0] pc_i = 16'h0100;
    logic [7:0] index_i = 8'h00;
    logic branch_cond_i = 1'b0;
    logic [7:0] opcode, byte1, byte2, mem_data, wd;
    logic ready_o, done_o, addr_valid_o, branch_taken_o, carry_o, carry_update_o, half_carry_o;
    aeu_mode_e mode_o;
    aeu_class_e class_o;
    logic [15:0] effective_address_o, next_pc_o;
    logic [7:0] addr_hi_o, addr_lo_o;
    int failures = 0;
    int tests_run = 0;
    int n;
    aeu_row_s rows [13];

    always #10 clock_i = ~clock_i;

    aeu_mem_model mem (.pc_i(pc_i), .opcode_o(opcode), .byte1_o(byte1), .byte2_o(byte2),
        .data_o(mem_data));

    // alu operands reuse the operand bytes so half carry varies per row
    aeu_address_unit uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .req_i(req_i), .opcode_i(opcode), .byte1_i(byte1), .byte2_i(byte2), .pc_i(pc_i),
        .index_i(index_i), .branch_cond_i(branch_cond_i), .mem_data_i(mem_data),
        .alu_a_i(byte1), .alu_b_i(byte2), .alu_cin_i(branch_cond_i), .ready_o(ready_o),
        .done_o(done_o), .mode_o(mode_o), .class_o(class_o), .addr_valid_o(addr_valid_o),
        .effective_address_o(effective_address_o), .addr_hi_o(addr_hi_o),
        .addr_lo_o(addr_lo_o), .next_pc_o(next_pc_o), .branch_taken_o(branch_taken_o),
        .bit_write_data_o(wd), .carry_o(carry_o), .carry_update_o(carry_update_o),
        .half_carry_o(half_carry_o));

    // =========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic load(input aeu_row_s r);
        mem.put(r.pc, r.op);
        mem.put(r.pc + 16'h0001, r.b1);
        mem.put(r.pc + 16'h0002, r.b2);
        mem.put({8'h00, r.b1}, r.md);
        pc_i = r.pc;
        index_i = r.x;
        branch_cond_i = r.cond;
    endtask

    // one request, counts clock edges after the take edge until done shows
    task automatic do_req(output int cnt);
        @(posedge clock_i);
        #1;
        req_i = 1'b1;
        @(posedge clock_i);
        #1;
        req_i = 1'b0;
        cnt = 0;
        while (done_o !== 1'b1 && cnt < 20)
        begin
            @(posedge clock_i);
            #1;
            cnt++;
        end
    endtask

    function automatic aeu_class_e exp_class(input logic [3:0] nib);
        if (nib == 4'h0)
            return AEU_CLASS_BIT_TEST;
        if (nib == 4'h1)
            return AEU_CLASS_BIT_MODIFY;
        if (nib == 4'h2)
            return AEU_CLASS_BRANCH;
        if (nib <= 4'h7)
            return AEU_CLASS_READ_MODIFY_WRITE;
        if (nib <= 4'h9)
            return AEU_CLASS_CONTROL;
        return AEU_CLASS_REGISTER_MEMORY;
    endfunction

    initial
    begin
        #200000;
        failures++;
        print_verdict();
    end

    // =========================================================
    // main sequence
    initial
    begin
        rows = '{
            '{8'hc6, 8'h12, 8'h34, 16'h0100, 8'h00, 1'h0, 8'h5a, 16'h1234, 16'h0103, 1'h0,
                1'h0, 8'h5a, 1'h0},
            '{8'hf6, 8'h08, 8'h08, 16'h0100, 8'h80, 1'h0, 8'h11, 16'h0080, 16'h0101, 1'h0,
                1'h0, 8'h11, 1'h1},
            '{8'he6, 8'hff, 8'h01, 16'h0100, 8'hff, 1'h0, 8'h22, 16'h01fe, 16'h0102, 1'h0,
                1'h0, 8'h22, 1'h1},
            '{8'hd6, 8'h12, 8'hf0, 16'h0100, 8'h20, 1'h0, 8'h33, 16'h1310, 16'h0103, 1'h0,
                1'h0, 8'h33, 1'h0},
            '{8'h20, 8'h80, 8'h00, 16'h0300, 8'h00, 1'h1, 8'h44, 16'h0000, 16'h0282, 1'h1,
                1'h0, 8'h44, 1'h0},
            '{8'h22, 8'h7f, 8'h00, 16'h0300, 8'h00, 1'h0, 8'h55, 16'h0000, 16'h0302, 1'h0,
                1'h0, 8'h55, 1'h0},
            '{8'h24, 8'h7f, 8'h00, 16'h0300, 8'h00, 1'h1, 8'h55, 16'h0000, 16'h0381, 1'h1,
                1'h0, 8'h55, 1'h1},
            '{8'h14, 8'h40, 8'h00, 16'h0100, 8'h00, 1'h0, 8'h00, 16'h0040, 16'h0102, 1'h0,
                1'h0, 8'h04, 1'h0},
            '{8'h15, 8'h41, 8'h00, 16'h0100, 8'h00, 1'h0, 8'hff, 16'h0041, 16'h0102, 1'h0,
                1'h0, 8'hfb, 1'h0},
            '{8'h06, 8'h50, 8'h80, 16'h0400, 8'h00, 1'h0, 8'h08, 16'h0050, 16'h0383, 1'h1,
                1'h1, 8'h08, 1'h0},
            '{8'h07, 8'h50, 8'h80, 16'h0400, 8'h00, 1'h0, 8'h08, 16'h0050, 16'h0403, 1'h0,
                1'h1, 8'h08, 1'h0},
            '{8'h0f, 8'h60, 8'h7f, 16'h0400, 8'h00, 1'h1, 8'h7f, 16'h0060, 16'h0482, 1'h1,
                1'h0, 8'h7f, 1'h1},
            '{8'hb6, 8'h33, 8'h00, 16'h0100, 8'h00, 1'h0, 8'h66, 16'h0033, 16'h0102, 1'h0,
                1'h0, 8'h66, 1'h0}};
        repeat (2) @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        check({ready_o, done_o, next_pc_o[13:0]}, 16'h8000);
        check(class_o, AEU_CLASS_CONTROL);
        for (int i = 0; i < 13; i++)
        begin
            load(rows[i]);
            do_req(n);
            check(n, 1);
            check(effective_address_o, rows[i].ea);
            check({addr_hi_o, addr_lo_o}, rows[i].ea);
            check(next_pc_o, rows[i].npc);
            check(branch_taken_o, rows[i].tk);
            check({carry_update_o, carry_o}, {rows[i].op[7:4] == 4'h0, rows[i].cy});
            check(wd, rows[i].wd);
            check(half_carry_o, rows[i].hc);
            check(addr_valid_o, rows[i].op[7:4] != 4'h2);
        end
        for (int i = 0; i < 16; i++)
        begin
            mem.put(16'h0100, {i[3:0], 4'h1});
            pc_i = 16'h0100;
            do_req(n);
            check(class_o, exp_class(i[3:0]));
        end
        // stall in calc with ce low while a second request is refused
        load(rows[0]);
        @(posedge clock_i);
        #1;
        req_i = 1'b1;
        @(posedge clock_i);
        #1;
        ce_i = 1'b0;
        mem.put(16'h0100, 8'hf6);
        repeat (3) @(posedge clock_i);
        #1;
        check({ready_o, done_o}, 16'h0000);
        ce_i = 1'b1;
        req_i = 1'b0;
        n = 0;
        while (done_o !== 1'b1 && n < 20)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        check(n, 1);
        check(effective_address_o, 16'h1234);
        // reset in mid-calculation drops the request
        load(rows[0]);
        @(posedge clock_i);
        #1;
        req_i = 1'b1;
        @(posedge clock_i);
        #1;
        req_i = 1'b0;
        reset_n_i = 1'b0;
        @(posedge clock_i);
        #1;
        reset_n_i = 1'b1;
        check({ready_o, done_o, effective_address_o[13:0]}, 16'h8000);
        @(posedge clock_i);
        #1;
        check(done_o, 1'b0);
        check(mode_o, AEU_INHERENT_MODE);
        print_verdict();
    end
endmodule // test_addressing_mode_ea_unit
